/* File: rtl/pwm_output_stage.sv */
`timescale 1ns/1ps
module pwm_output_stage #(
  parameter int NUM_CHAN = pwm_out_pkg::NUM_CHAN,
  parameter int NUM_GEN  = pwm_out_pkg::NUM_GEN
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // Generator side
  input  wire logic [5:0]  gen_sig_in,
  input  wire logic [2:0]  gen_irq_in,
  input  wire logic        debug_event_in,
  input  wire logic        fault_in,
  // Pins and interrupt
  output logic      [5:0]  pwm_pin_out,
  output logic             irq_out
);
  // Decoded register strobes
  logic        wr_pin_enable;
  logic        wr_polarity;
  logic        wr_trip_action;
  logic        wr_irq_enable;
  logic        wr_sts_clr;
  logic        rd_pin_enable;
  logic        rd_polarity;
  logic        rd_trip_action;
  logic        rd_irq_enable;
  logic        rd_irq_raw;
  logic        rd_sts_clr;

  // Configuration state
  logic [5:0]  pin_enable_reg;
  logic [5:0]  pin_enable_next;
  logic [5:0]  polarity_reg;
  logic [5:0]  polarity_next;
  logic [5:0]  trip_action_reg;
  logic [5:0]  trip_action_next;
  logic [31:0] irq_enable_reg;
  logic [31:0] irq_enable_next;

  // Interrupt state
  logic        trip_flag_reg;
  logic        trip_flag_next;
  logic        fault_prev_reg;
  logic        fault_rise;
  logic        trip_clear;
  logic [31:0] raw_status;
  logic [31:0] masked_status;
  logic        irq_reg;
  logic        irq_next;

  // Read path
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] cfg_enable_word;
  logic [31:0] cfg_polarity_word;
  logic [31:0] cfg_trip_word;
  logic [31:0] cfg_irq_en_word;
  logic [31:0] cfg_raw_word;
  logic [31:0] cfg_sts_word;

  // Pin path
  logic        trip_active;

  // Ports are sized for six channels and three generators
  if (NUM_CHAN != 6) begin : g_chan_check
    $error("pwm_output_stage: NUM_CHAN must be 6");
  end

  if (NUM_GEN != 3) begin : g_gen_check
    $error("pwm_output_stage: NUM_GEN must be 3");
  end

  if ($bits(pwm_out_pkg::CHAN_RESET) != NUM_CHAN) begin : g_reset_check
    $error("pwm_output_stage: channel reset width mismatch");
  end

  // Generator bits share one word with the trip bit
  if (pwm_out_pkg::GEN_LSB + NUM_GEN > pwm_out_pkg::TRIP_BIT) begin : g_field_check
    $error("pwm_output_stage: generator field overlaps trip bit");
  end

  if (pwm_out_pkg::TRIP_BIT > 31) begin : g_trip_check
    $error("pwm_output_stage: trip bit outside the word");
  end

  if (pwm_out_pkg::IRQ_MASK != ((32'h1 << pwm_out_pkg::TRIP_BIT)
      | (((32'h1 << NUM_GEN) - 32'h1) << pwm_out_pkg::GEN_LSB))) begin : g_mask_check
    $error("pwm_output_stage: enable mask does not match the sources");
  end

  if ((pwm_out_pkg::IRQ_EN_RESET & ~pwm_out_pkg::IRQ_MASK) != 32'h0) begin : g_en_rst_check
    $error("pwm_output_stage: enable reset sets unused bits");
  end

  // Word-aligned offsets only; the decode compares whole addresses
  if (pwm_out_pkg::OFS_PIN_ENABLE[1:0] != 2'b00) begin : g_ofs0_check
    $error("pwm_output_stage: enable offset not word aligned");
  end
  if (pwm_out_pkg::OFS_POLARITY[1:0] != 2'b00) begin : g_ofs1_check
    $error("pwm_output_stage: polarity offset not word aligned");
  end
  if (pwm_out_pkg::OFS_TRIP_ACTION[1:0] != 2'b00) begin : g_ofs2_check
    $error("pwm_output_stage: trip offset not word aligned");
  end
  if (pwm_out_pkg::OFS_IRQ_ENABLE[1:0] != 2'b00) begin : g_ofs3_check
    $error("pwm_output_stage: irq enable offset not word aligned");
  end
  if (pwm_out_pkg::OFS_IRQ_RAW[1:0] != 2'b00) begin : g_ofs4_check
    $error("pwm_output_stage: raw offset not word aligned");
  end
  if (pwm_out_pkg::OFS_IRQ_STS_CLR[1:0] != 2'b00) begin : g_ofs5_check
    $error("pwm_output_stage: clear offset not word aligned");
  end

  pwm_out_if chan_bus ();

  pwm_chan_stage u_stage (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .bus        (chan_bus.stage)
  );

  // Write decode, one strobe per writable register
  assign wr_pin_enable  = reg_wr_in
                          && (reg_addr_in == pwm_out_pkg::OFS_PIN_ENABLE);
  assign wr_polarity    = reg_wr_in
                          && (reg_addr_in == pwm_out_pkg::OFS_POLARITY);
  assign wr_trip_action = reg_wr_in
                          && (reg_addr_in == pwm_out_pkg::OFS_TRIP_ACTION);
  assign wr_irq_enable  = reg_wr_in
                          && (reg_addr_in == pwm_out_pkg::OFS_IRQ_ENABLE);
  assign wr_sts_clr     = reg_wr_in
                          && (reg_addr_in == pwm_out_pkg::OFS_IRQ_STS_CLR);

  // Read selects
  assign rd_pin_enable  = reg_rd_in
                          && (reg_addr_in == pwm_out_pkg::OFS_PIN_ENABLE);
  assign rd_polarity    = reg_rd_in
                          && (reg_addr_in == pwm_out_pkg::OFS_POLARITY);
  assign rd_trip_action = reg_rd_in
                          && (reg_addr_in == pwm_out_pkg::OFS_TRIP_ACTION);
  assign rd_irq_enable  = reg_rd_in
                          && (reg_addr_in == pwm_out_pkg::OFS_IRQ_ENABLE);
  assign rd_irq_raw     = reg_rd_in
                          && (reg_addr_in == pwm_out_pkg::OFS_IRQ_RAW);
  assign rd_sts_clr     = reg_rd_in
                          && (reg_addr_in == pwm_out_pkg::OFS_IRQ_STS_CLR);

  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_enable_bit
    assign pin_enable_next[ch] = wr_pin_enable ? reg_wdata_in[ch] : pin_enable_reg[ch];
  end

  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_polarity_bit
    assign polarity_next[ch] = wr_polarity ? reg_wdata_in[ch] : polarity_reg[ch];
  end

  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_trip_bit
    assign trip_action_next[ch] = wr_trip_action ? reg_wdata_in[ch] : trip_action_reg[ch];
  end

  // Only the documented enable bits are kept
  always_comb begin
    irq_enable_next = irq_enable_reg;
    if (wr_irq_enable) begin
      irq_enable_next = reg_wdata_in & pwm_out_pkg::IRQ_MASK;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_enable_reg <= pwm_out_pkg::CHAN_RESET;
    end else begin
      pin_enable_reg <= pin_enable_next;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      polarity_reg <= pwm_out_pkg::CHAN_RESET;
    end else begin
      polarity_reg <= polarity_next;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      trip_action_reg <= pwm_out_pkg::CHAN_RESET;
    end else begin
      trip_action_reg <= trip_action_next;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_enable_reg <= pwm_out_pkg::IRQ_EN_RESET;
    end else begin
      irq_enable_reg <= irq_enable_next;
    end
  end

  // A debug event trips the channels like a fault; trip_low channels are forced inactive
  assign chan_bus.gen_sig     = gen_sig_in;
  assign chan_bus.pin_en      = pin_enable_reg;
  assign chan_bus.polarity    = polarity_reg;
  assign chan_bus.trip_low    = trip_action_reg;
  assign trip_active          = fault_in | debug_event_in;
  assign chan_bus.trip_active = trip_active;
  assign pwm_pin_out          = chan_bus.pin_val;

  // Edge detect on a synchronous input; no synchroniser needed
  assign fault_rise = fault_in & ~fault_prev_reg;
  assign trip_clear = wr_sts_clr && reg_wdata_in[pwm_out_pkg::TRIP_BIT];

  // Latch, set wins so a fault is never lost to a clear
  always_comb begin
    trip_flag_next = trip_flag_reg;
    if (fault_rise) begin
      trip_flag_next = 1'b1;
    end else if (trip_clear) begin
      trip_flag_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_prev_reg <= 1'b0;
    end else begin
      fault_prev_reg <= fault_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      trip_flag_reg <= 1'b0;
    end else begin
      trip_flag_reg <= trip_flag_next;
    end
  end

  // Raw view; generator bits mirror their sources
  for (genvar b = 0; b < 32; b++) begin : g_raw_bit
    if (b == pwm_out_pkg::TRIP_BIT) begin : g_trip
      assign raw_status[b] = trip_flag_reg;
    end else if ((b >= pwm_out_pkg::GEN_LSB)
                 && (b < pwm_out_pkg::GEN_LSB + NUM_GEN)) begin : g_gen
      assign raw_status[b] = gen_irq_in[b - pwm_out_pkg::GEN_LSB];
    end else begin : g_rsvd
      assign raw_status[b] = 1'b0;
    end
  end

  assign masked_status = raw_status & irq_enable_reg;

  assign irq_next = |masked_status;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end
  assign irq_out = irq_reg;

  assign cfg_enable_word   = {26'h0, pin_enable_reg};
  assign cfg_polarity_word = {26'h0, polarity_reg};
  assign cfg_trip_word     = {26'h0, trip_action_reg};
  assign cfg_irq_en_word   = irq_enable_reg;
  assign cfg_raw_word      = raw_status;
  assign cfg_sts_word      = masked_status;

  // Unmapped and idle cycles return zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_pin_enable) begin
      rdata_next = cfg_enable_word;
    end else if (rd_polarity) begin
      rdata_next = cfg_polarity_word;
    end else if (rd_trip_action) begin
      rdata_next = cfg_trip_word;
    end else if (rd_irq_enable) begin
      rdata_next = cfg_irq_en_word;
    end else if (rd_irq_raw) begin
      rdata_next = cfg_raw_word;
    end else if (rd_sts_clr) begin
      rdata_next = cfg_sts_word;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata_out = rdata_reg;
endmodule

/* File: rtl/pwm_out_pkg.sv */
package pwm_out_pkg;
  localparam int          NUM_CHAN          = 6;
  localparam int          NUM_GEN           = 3;
  localparam int          ADDR_W            = 12;
  localparam logic [11:0] OFS_PIN_ENABLE    = 12'h008;
  localparam logic [11:0] OFS_POLARITY      = 12'h00c;
  localparam logic [11:0] OFS_TRIP_ACTION   = 12'h010;
  localparam logic [11:0] OFS_IRQ_ENABLE    = 12'h014;
  localparam logic [11:0] OFS_IRQ_RAW       = 12'h018;
  localparam logic [11:0] OFS_IRQ_STS_CLR   = 12'h01c;
  localparam int          TRIP_BIT          = 16;
  localparam int          GEN_LSB           = 0;
  localparam logic [5:0]  CHAN_RESET        = 6'h00;
  localparam logic [31:0] IRQ_EN_RESET      = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK          = 32'h0001_0007;
endpackage

/* File: rtl/pwm_out_if.sv */
`timescale 1ns/1ps
interface pwm_out_if;
  logic [5:0] gen_sig;
  logic [5:0] pin_en;
  logic [5:0] polarity;
  logic [5:0] trip_low;
  logic       trip_active;
  logic [5:0] pin_val;
  modport ctrl (output gen_sig, output pin_en, output polarity, output trip_low,
                output trip_active, input pin_val);
  modport stage (input gen_sig, input pin_en, input polarity, input trip_low,
                 input trip_active, output pin_val);
endinterface

/* File: rtl/pwm_chan_stage.sv */
`timescale 1ns/1ps
module pwm_chan_stage (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // Channel controls
  pwm_out_if.stage  bus
);
  logic [5:0] pin_reg;
  logic [5:0] stage_next;

  always_comb begin
    stage_next = bus.gen_sig & bus.pin_en;
    if (bus.trip_active) begin
      stage_next = stage_next & ~bus.trip_low;
    end
    stage_next = stage_next ^ bus.polarity;
  end

  // Registered pins avoid glitches on the drivers
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_reg <= pwm_out_pkg::CHAN_RESET;
    end else begin
      pin_reg <= stage_next;
    end
  end

  assign bus.pin_val = pin_reg;
endmodule

/* File: tb/pwm_out_properties.sv */
`timescale 1ns/1ps
module pwm_out_properties (
  // Clock, reset, register port
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Generator side and pins
  input wire logic [5:0]  gen_sig_in,
  input wire logic [2:0]  gen_irq_in,
  input wire logic        debug_event_in,
  input wire logic        fault_in,
  input wire logic [5:0]  pwm_pin_out,
  input wire logic        irq_out
);
  logic [16:0] sh [2:5];
  logic        trip;
  logic        rd_raw;
  logic [5:0]  exp_pin;
  // Shadow copy, since the real registers are hidden behind the port
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in) sh <= '{default: 17'h0};
    else if (reg_wr_in && reg_addr_in inside {12'h008, 12'h00c, 12'h010, 12'h014})
      sh[reg_addr_in[4:2]] <= reg_wdata_in[16:0];
  assign trip = fault_in | debug_event_in;
  assign rd_raw = reg_rd_in && reg_addr_in == 12'h018;
  assign exp_pin = (gen_sig_in & sh[2][5:0] & ~(trip ? sh[4][5:0] : 6'h00)) ^ sh[3][5:0];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rise; !fault_in ##1 fault_in; endsequence
  sequence s_clr; reg_wr_in && reg_addr_in == 12'h01c && reg_wdata_in[16] && !fault_in;
  endsequence
  a_pin_path: assert property (pwm_pin_out == $past(exp_pin))
    else $error("pin level wrong");
  a_trip_low: assert property ($past(trip) |->
    ((pwm_pin_out ^ $past(sh[3][5:0])) & $past(sh[4][5:0])) == 6'h00) else $error("trip level");
  a_raw_gen: assert property (rd_raw && $stable(gen_irq_in) |=>
    reg_rdata_out[2:0] == $past(gen_irq_in)) else $error("raw generator bits wrong");
  a_fault_set: assert property (s_rise ##1 rd_raw |=> reg_rdata_out[16])
    else $error("fault not latched");
  a_fault_clr: assert property (s_clr ##1 (rd_raw && !fault_in) |=> !reg_rdata_out[16])
    else $error("fault not cleared");
  a_rsvd_zero: assert property ($past(reg_rd_in && reg_addr_in inside
    {12'h008, 12'h00c, 12'h010}) |-> reg_rdata_out[31:6] == 26'h0) else $error("reserved set");
  a_irq_off: assert property ((sh[5][16] == 1'b0 && sh[5][2:0] == 3'h0) [*3] |-> !irq_out)
    else $error("irq while disabled");
  a_irq_gen: assert property (((sh[5][2:0] & gen_irq_in) != 3'h0) [*3] |-> irq_out)
    else $error("irq missing");
endmodule
bind pwm_output_stage pwm_out_properties i_props (.*);

/* File: tb/pwm_trip_src.sv */
`timescale 1ns/1ps
module pwm_trip_src (
  // Clock and request
  input  wire logic clk_in,
  input  wire logic trip_req_in,
  // Fault line
  output logic      fault_out
);
  initial fault_out = 1'b0;
  // Registered, so the fault edge lands a cycle after the request
  always @(posedge clk_in) fault_out <= trip_req_in;
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        ref_clk_in;
  logic        rst_in;
  logic [11:0] reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [31:0] reg_rdata_out;
  logic [5:0]  gen_sig_in;
  logic [2:0]  gen_irq_in;
  logic        debug_event_in;
  logic        fault_in;
  logic        trip_req;
  logic [5:0]  pwm_pin_out;
  logic        irq_out;
  int          n_mismatch;
  int          cmp_count;
  int          cycles;
  logic [11:0] addrs [6] = '{12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h100};
  pwm_output_stage i_dut (.*);
  pwm_trip_src i_src (.clk_in(ref_clk_in), .trip_req_in(trip_req), .fault_out(fault_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  task automatic close_out();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
    @(posedge ref_clk_in);
  endtask
  // Pins and irq settle within three cycles of any cause
  task automatic look(input logic [6:0] e);
    repeat (3) @(posedge ref_clk_in);
    #1 chk({25'h0, irq_out, pwm_pin_out}, {25'h0, e});
    @(posedge ref_clk_in);
  endtask
  initial begin
    rst_in = 1'b1;
    {reg_wr_in, reg_rd_in, debug_event_in, trip_req, gen_irq_in} = 7'h00;
    {reg_addr_in, reg_wdata_in, gen_sig_in} = '0;
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    foreach (addrs[i]) rd(addrs[i], 32'h0);
    wr(12'h008, 32'hffff_ffff);
    rd(12'h008, 32'h3f);
    wr(12'h00c, 32'hffff_ffd5);
    rd(12'h00c, 32'h15);
    gen_sig_in <= 6'h2d;
    look({1'b0, 6'h2d ^ 6'h15});
    wr(12'h008, 32'h0f);
    look({1'b0, 6'h0d ^ 6'h15});
    wr(12'h010, 32'h33);
    debug_event_in <= 1'b1;
    look({1'b0, (6'h0d & 6'h0c) ^ 6'h15});
    debug_event_in <= 1'b0;
    trip_req <= 1'b1;
    gen_irq_in <= 3'h5;
    repeat (2) @(posedge ref_clk_in);
    rd(12'h018, 32'h0001_0005);
    look({1'b0, 6'h0c ^ 6'h15});
    trip_req <= 1'b0;
    wr(12'h01c, 32'h0);
    rd(12'h018, 32'h0001_0005);
    wr(12'h014, 32'h0001_0000);
    look({1'b1, 6'h0d ^ 6'h15});
    wr(12'h01c, 32'h0001_0000);
    rd(12'h018, 32'h5);
    look({1'b0, 6'h0d ^ 6'h15});
    wr(12'h014, 32'h4);
    look({1'b1, 6'h0d ^ 6'h15});
    rd(12'h01c, 32'h4);
    gen_irq_in <= 3'h1;
    look({1'b0, 6'h0d ^ 6'h15});
    rd(12'h018, 32'h1);
    close_out();
  end
endmodule
